// >>> hdl/fpeg_guard.sv
// flash program and erase guard: key, enables, timing, lock, faults
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fpeg_regs.svh"
module fpeg_guard #(
	parameter int FLASH_BYTES = 16384,
	parameter int PAGE_BYTES = 512,
	parameter int ERASE_CYC = `FPEG_ERASE_CYC,
	parameter int WRITE_CYC = `FPEG_WRITE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// core data-move and code-move accesses
	input fpeg_pkg::fpeg_req_s coreReq,
	input wire logic codeRd,
	input wire logic [13:0] codeAddr,
	input wire logic [13:0] corePc,
	output logic [7:0] codeRdata,
	output logic xramWr,
	output logic xramRd,
	output logic [13:0] xramAddr,
	output logic [7:0] xramWdata,
	output logic coreStall,
	// debug port accesses
	input fpeg_pkg::fpeg_req_s dbgReq,
	output logic [7:0] dbgRdata,
	output logic dbgBusy,
	// supply monitor state and fault reset
	input wire logic supMonEn,
	input wire logic supMonRstSel,
	input wire logic porEvent,
	output logic faultResetReq
);
	import fpeg_pkg::*;
	localparam int AW = 14;
	localparam int PAGE_SH = 9;
	localparam int CW = $clog2(ERASE_CYC + 1);

	initial begin
		if (FLASH_BYTES != 16384 || PAGE_BYTES != 512)
			$error("fpeg_guard: only 16384 bytes in 512-byte pages");
		if (WRITE_CYC < 1 || ERASE_CYC < WRITE_CYC)
			$error("fpeg_guard: bad timing counts");
	end

	// flash array, blank (all ones) as a fresh device ships
	logic [7:0] flashMem [0:FLASH_BYTES-1] = '{default: 8'hFF};

	// page of an address
	function automatic logic [4:0] pageOf(input logic [AW-1:0] a);
		pageOf = a[AW-1:PAGE_SH];
	endfunction

	// page is locked under a lock count
	function automatic logic isLocked(input logic [AW-1:0] a,
			input logic [7:0] n);
		logic lockPg;
		lockPg = (pageOf(a) == pageOf(`FPEG_LOCK_ADDR)) && (n != 8'h00);
		isLocked = ({3'b000, pageOf(a)} < n) || lockPg;
	endfunction

	// state
	logic weR, weNxt, eeR, eeNxt;
	logic ferrR, ferrNxt;
	logic [7:0] lockCntR, lockCntNxt;
	logic lockLoadR, lockLoadNxt;
	fpeg_op_e opR, opNxt;
	logic [AW-1:0] opAddrR, opAddrNxt;
	logic [7:0] opDataR, opDataNxt;
	logic faultR, faultNxt;
	logic [7:0] rdataR, rdataNxt;
	logic [7:0] codeRdR, codeRdNxt;
	logic [7:0] dbgRdR, dbgRdNxt;
	logic xWrR, xWrNxt, xRdR, xRdNxt;
	logic [AW-1:0] xAddrR, xAddrNxt;
	logic [7:0] xDataR, xDataNxt;

	// key machine and timer hookup
	fpeg_key_e keyState;
	logic keyWr, modAttempt, tStart, tBusy, tDone;
	logic [CW-1:0] tLoad;

	fpeg_key_fsm u_key (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.keyWr(keyWr),
		.keyData(regWdata),
		.modAttempt(modAttempt),
		.opDone(tDone),
		.keyState(keyState)
	);

	fpeg_op_timer #(.CNT_W(CW)) u_tmr (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.start(tStart),
		.loadCnt(tLoad),
		.busy(tBusy),
		.done(tDone)
	);

	// access classification
	logic coreFlashWr, userRange, fromLocked, tgtLocked, lockPgErase;
	logic supplyBad, coreDenied, dbgWrOk, dbgDenied;
	always_comb begin
		keyWr = regWr && (regAddr == `FPEG_OFS_KEY);
		coreFlashWr = coreReq.valid && coreReq.wr && weR && !tBusy;
		userRange = coreReq.addr <= `FPEG_LAST_USER;
		fromLocked = isLocked(corePc, lockCntR);
		tgtLocked = isLocked(coreReq.addr, lockCntR);
		lockPgErase = eeR && (pageOf(coreReq.addr) ==
			pageOf(`FPEG_LOCK_ADDR)) && (lockCntR != 8'h00);
		supplyBad = !supMonEn || !supMonRstSel;
		coreDenied = !userRange || supplyBad || lockPgErase ||
			(tgtLocked && !fromLocked);
		modAttempt = coreFlashWr && !coreDenied;
		dbgWrOk = dbgReq.valid && dbgReq.wr && !tBusy &&
			(dbgReq.addr <= `FPEG_LAST_USER);
		dbgDenied = isLocked(dbgReq.addr, lockCntR);
	end

	// register, operation and routing next state
	always_comb begin
		weNxt = weR;
		eeNxt = eeR;
		ferrNxt = ferrR;
		lockCntNxt = lockCntR;
		lockLoadNxt = 1'b0;
		opNxt = opR;
		opAddrNxt = opAddrR;
		opDataNxt = opDataR;
		faultNxt = 1'b0;
		rdataNxt = 8'h00;
		codeRdNxt = codeRdR;
		dbgRdNxt = dbgRdR;
		xWrNxt = 1'b0;
		xRdNxt = 1'b0;
		xAddrNxt = xAddrR;
		xDataNxt = xDataR;
		tStart = 1'b0;
		tLoad = '0;
		// lock count loads one cycle after reset release
		if (lockLoadR)
			lockCntNxt = ~flashMem[`FPEG_LOCK_ADDR];
		// software register writes
		if (regWr && regAddr == `FPEG_OFS_CTRL) begin
			weNxt = regWdata[`FPEG_CTRL_WE];
			eeNxt = regWdata[`FPEG_CTRL_EE];
		end
		// register reads, data one cycle later
		if (regRd) begin
			case (regAddr)
				`FPEG_OFS_CTRL: rdataNxt = {6'b0, eeR, weR};
				`FPEG_OFS_CAUSE:
					rdataNxt = {1'b0, ferrR, 6'b0};
				`FPEG_OFS_STAT:
					rdataNxt = {4'b0, tBusy, keyState[1:0], 1'b0};
				default: rdataNxt = 8'h00;
			endcase
		end
		// data-move reads and plain writes go to external ram
		if (coreReq.valid && !coreReq.wr) begin
			xRdNxt = 1'b1;
			xAddrNxt = coreReq.addr;
		end else if (coreReq.valid && coreReq.wr && !weR) begin
			xWrNxt = 1'b1;
			xAddrNxt = coreReq.addr;
			xDataNxt = coreReq.data;
		end
		// code-move flash reads
		if (codeRd && !tBusy) begin
			if (codeAddr > `FPEG_LAST_USER ||
					(isLocked(codeAddr, lockCntR) &&
					!isLocked(corePc, lockCntR)))
				faultNxt = 1'b1;
			else
				codeRdNxt = flashMem[codeAddr];
		end
		// debug port reads, denied ones ignored
		if (dbgReq.valid && !dbgReq.wr && !dbgDenied)
			dbgRdNxt = flashMem[dbgReq.addr];
		// firmware flash write or erase
		if (coreFlashWr) begin
			if (coreDenied) begin
				faultNxt = 1'b1;
			end else if (keyState == FPEG_KEY_OPEN) begin
				opAddrNxt = coreReq.addr;
				opDataNxt = coreReq.data;
				tStart = 1'b1;
				if (eeR) begin
					opNxt = FPEG_OP_ERASE;
					tLoad = CW'(ERASE_CYC);
				end else begin
					opNxt = FPEG_OP_WRITE;
					tLoad = CW'(WRITE_CYC);
				end
			end
		end else if (dbgWrOk && !dbgDenied) begin
			opAddrNxt = dbgReq.addr;
			opDataNxt = dbgReq.data;
			opNxt = FPEG_OP_WRITE;
			tStart = 1'b1;
			tLoad = CW'(WRITE_CYC);
		end
		if (tDone)
			opNxt = FPEG_OP_IDLE;
		// fault flag: set on fault reset, cleared only by a power-on event
		if (faultR)
			ferrNxt = 1'b1;
		else if (porEvent)
			ferrNxt = 1'b0;
	end

	// flash array update at end of operation
	always_ff @(posedge ref_clk) begin
		if (tDone && opR == FPEG_OP_WRITE)
			flashMem[opAddrR] <= flashMem[opAddrR] & opDataR;
		else if (tDone && opR == FPEG_OP_ERASE) begin
			for (int i = 0; i < PAGE_BYTES; i++)
				flashMem[{pageOf(opAddrR), PAGE_SH'(i)}] <=
					`FPEG_ERASED;
		end
	end

	// fault flag survives the fault reset it causes
	always_ff @(posedge ref_clk) begin
		ferrR <= ferrNxt;
	end

	// state registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			weR <= 1'b0;
			eeR <= 1'b0;
			lockCntR <= 8'h00;
			lockLoadR <= 1'b1;
			opR <= FPEG_OP_IDLE;
			opAddrR <= '0;
			opDataR <= 8'h00;
			faultR <= 1'b0;
			rdataR <= 8'h00;
			codeRdR <= 8'h00;
			dbgRdR <= 8'h00;
			xWrR <= 1'b0;
			xRdR <= 1'b0;
			xAddrR <= '0;
			xDataR <= 8'h00;
		end else begin
			weR <= weNxt;
			eeR <= eeNxt;
			lockCntR <= lockCntNxt;
			lockLoadR <= lockLoadNxt;
			opR <= opNxt;
			opAddrR <= opAddrNxt;
			opDataR <= opDataNxt;
			faultR <= faultNxt;
			rdataR <= rdataNxt;
			codeRdR <= codeRdNxt;
			dbgRdR <= dbgRdNxt;
			xWrR <= xWrNxt;
			xRdR <= xRdNxt;
			xAddrR <= xAddrNxt;
			xDataR <= xDataNxt;
		end
	end

	// outputs straight from flops
	assign regRdata = rdataR;
	assign codeRdata = codeRdR;
	assign dbgRdata = dbgRdR;
	assign xramWr = xWrR;
	assign xramRd = xRdR;
	assign xramAddr = xAddrR;
	assign xramWdata = xDataR;
	assign coreStall = tBusy;
	assign dbgBusy = tBusy;
	assign faultResetReq = faultR;
endmodule

// >>> hdl/fpeg_key_fsm.sv
// two-code unlock state machine with sticky disable
`timescale 1ns/1ps
`include "fpeg_regs.svh"
module fpeg_key_fsm (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// key register write
	input wire logic keyWr,
	input wire logic [7:0] keyData,
	// modify attempt and its completion
	input wire logic modAttempt,
	input wire logic opDone,
	// state out
	output fpeg_pkg::fpeg_key_e keyState
);
	import fpeg_pkg::*;
	fpeg_key_e key_r, key_nxt;

	// next key state
	always_comb begin
		key_nxt = key_r;
		case (key_r)
			FPEG_KEY_LOCKED: begin
				if (modAttempt)
					key_nxt = FPEG_KEY_DEAD;
				else if (keyWr)
					key_nxt = (keyData == `FPEG_KEY_FIRST) ?
						FPEG_KEY_FIRST : FPEG_KEY_DEAD;
			end
			FPEG_KEY_FIRST: begin
				if (modAttempt)
					key_nxt = FPEG_KEY_DEAD;
				else if (keyWr)
					key_nxt = (keyData == `FPEG_KEY_SECOND) ?
						FPEG_KEY_OPEN : FPEG_KEY_DEAD;
			end
			FPEG_KEY_OPEN: begin
				if (keyWr)
					key_nxt = FPEG_KEY_DEAD;
				else if (opDone)
					key_nxt = FPEG_KEY_LOCKED;
			end
			FPEG_KEY_DEAD: key_nxt = FPEG_KEY_DEAD;
			default: key_nxt = FPEG_KEY_DEAD;
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			key_r <= FPEG_KEY_LOCKED;
		else
			key_r <= key_nxt;
	end

	assign keyState = key_r;
endmodule

// >>> hdl/fpeg_op_timer.sv
// down counter timing one byte write or page erase
`timescale 1ns/1ps
`include "fpeg_regs.svh"
module fpeg_op_timer #(
	parameter int CNT_W = 21
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// start with a load count
	input wire logic start,
	input wire logic [CNT_W-1:0] loadCnt,
	// status
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;

	initial begin
		if (CNT_W < 2)
			$error("fpeg_op_timer: CNT_W too small");
	end

	// count down while busy, pulse done when count reaches one
	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (start && !busy_r) begin
			cnt_nxt = loadCnt;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r <= CNT_W'(1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - CNT_W'(1);
			end
		end
	end

	// timer registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
endmodule

// >>> hdl/fpeg_pkg.sv
// types shared by the flash guard files
package fpeg_pkg;
	typedef enum logic [2:0] {
		FPEG_KEY_LOCKED = 3'b000,
		FPEG_KEY_FIRST = 3'b001,
		FPEG_KEY_OPEN = 3'b010,
		FPEG_KEY_DEAD = 3'b011
	} fpeg_key_e;

	typedef enum logic [1:0] {
		FPEG_OP_IDLE = 2'b00,
		FPEG_OP_WRITE = 2'b01,
		FPEG_OP_ERASE = 2'b10
	} fpeg_op_e;

	// one flash access request from core or debug port
	typedef struct packed {
		logic valid;
		logic wr;
		logic [13:0] addr;
		logic [7:0] data;
	} fpeg_req_s;
endpackage

// >>> hdl/fpeg_regs.svh
// offsets, fields, key codes and timing counts of the flash guard
// Notes on behaviour
// - key register must get first code then second code; timing free
// - wrong key value or order blocks flash modify until system reset
// - modify attempt before full key sequence also blocks until reset
// - key relocks after every write or erase; new sequence each time
// - write enable steers data-move writes to flash; stays until cleared
// - modify needs write enable; erase needs write and erase enable
// - erase clears whole 512-byte page holding the address to all ones
// - both enables plus unlocked: data write erases page, data ignored
// - writes only clear bits; only erase sets bits back to one
// - write enable only plus unlocked: data write programs one byte
// - write and erase self-timed, stall core, no polling needed
// - top 512 bytes reserved, no software read write or erase
// - data-move reads go to external data ram, never flash
// - lock byte at last user byte; its complement counts locked pages
// - locked pages guarded from debug port and unlocked-page code
// - fault flag reads one after flash-error reset, else zero; the guard clears it only on a power-on event
// - debug port programs bytes; only path for blank device
// - software write or erase above last user address: fault reset
// - firmware denied by page lock: fault reset; debug port ignored
// - modify with supply monitor or its reset off: fault reset
`ifndef FPEG_REGS_SVH
`define FPEG_REGS_SVH

// register offsets on the plain port
`define FPEG_OFS_KEY 8'h00
`define FPEG_OFS_CTRL 8'h01
`define FPEG_OFS_CAUSE 8'h02
`define FPEG_OFS_STAT 8'h03
// control and cause field positions
`define FPEG_CTRL_WE 0
`define FPEG_CTRL_EE 1
`define FPEG_CAUSE_FERR 6
// key codes
`define FPEG_KEY_FIRST 8'hA5
`define FPEG_KEY_SECOND 8'hF1
// memory map
`define FPEG_LAST_USER 14'h3DFF
`define FPEG_LOCK_ADDR 14'h3DFF
`define FPEG_ERASED 8'hFF
// timing
`define FPEG_CLK_MHZ 100
`define FPEG_ERASE_US 15000
`define FPEG_WRITE_US 55
`define FPEG_ERASE_CYC (`FPEG_ERASE_US * `FPEG_CLK_MHZ)
`define FPEG_WRITE_CYC (`FPEG_WRITE_US * `FPEG_CLK_MHZ)

`endif

// >>> verif/fpeg_core_model.sv
// core model issuing data-move and code-move requests
`timescale 1ns/1ps
module fpeg_core_model (
	// clock
	input wire logic ref_clk,
	// requests toward the guard
	output fpeg_pkg::fpeg_req_s coreReq,
	output logic codeRd,
	output logic [13:0] codeAddr
);
	import fpeg_pkg::*;
	// idle at time zero
	initial begin
		coreReq = '0;
		codeRd = 1'b0;
		codeAddr = 14'h0000;
	end
	// one data-move cycle, then idle fields scrambled
	task automatic dm(input logic wr, input logic [13:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		coreReq <= {1'b1, wr, a, d};
		@(posedge ref_clk);
		coreReq <= {1'b0, ~wr, ~a, ~d};
	endtask
	// one code-move read
	task automatic cm(input logic [13:0] a);
		@(posedge ref_clk);
		codeRd <= 1'b1;
		codeAddr <= a;
		@(posedge ref_clk);
		codeRd <= 1'b0;
		codeAddr <= ~a;
	endtask
endmodule

// >>> verif/fpeg_guard_chk.sv
// assertions on the flash guard ports
`timescale 1ns/1ps
module fpeg_guard_chk #(
	parameter int ERASE_CYC = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register and core side
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input fpeg_pkg::fpeg_req_s coreReq,
	input wire logic supMonEn,
	// guard outputs
	input wire logic coreStall,
	input wire logic xramWr,
	input wire logic xramRd,
	input wire logic [13:0] xramAddr,
	input wire logic faultResetReq
);
	import fpeg_pkg::*;
	logic weR, weNxt, wrReq;
	int runR, runNxt;
	assign wrReq = coreReq.valid && coreReq.wr && !coreStall;
	// shadow write enable, length of stall run
	always_comb begin
		weNxt = weR;
		if (regWr && regAddr == 8'h01)
			weNxt = regWdata[0];
		runNxt = coreStall ? runR + 1 : 0;
	end
	always_ff @(posedge ref_clk) begin
		weR <= reset_n ? weNxt : 1'b0;
		runR <= reset_n ? runNxt : 0;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_read_to_external_data_ram: assert property (
		coreReq.valid && !coreReq.wr && !coreStall
		|=> xramRd && xramAddr == $past(coreReq.addr)
	) else $error("data read not sent to external ram");
	a_steer_external_data_ram: assert property (
		wrReq && !weR |=> xramWr
	) else $error("plain write not sent to external ram");
	a_steer_flash: assert property (
		wrReq && weR |=> !xramWr
	) else $error("flash write leaked to external ram");
	a_no_stall_we: assert property (
		wrReq && !weR |=> !coreStall[*3]
	) else $error("stall without write enable");
	a_stall_min: assert property (
		$rose(coreStall) |-> coreStall[*5]
	) else $error("stall shorter than a byte write");
	a_stall_max: assert property (
		runR <= ERASE_CYC + 1
	) else $error("stall longer than an erase");
	a_user_fault: assert property (
		wrReq && weR && coreReq.addr > 14'h3DFF |-> ##[1:2] faultResetReq
	) else $error("reserved write gave no fault reset");
	a_supply_fault: assert property (
		wrReq && weR && !supMonEn |-> ##[1:2] faultResetReq
	) else $error("write with monitor off gave no fault");
	c_stall: cover property ($rose(coreStall));
	c_fault: cover property ($rose(faultResetReq));
	c_external_data_ram: cover property (xramWr);
endmodule

// >>> verif/fpeg_guard_test.sv
// self-checking bench for the flash guard
`timescale 1ns/1ps
`include "fpeg_regs.svh"
module fpeg_guard_test;
	import fpeg_pkg::*;
	typedef struct {logic wr; logic [13:0] a; logic [7:0] d;} fpeg_row_s;
	typedef struct {logic sm; logic sel; logic code; logic [13:0] a;} fpeg_flt_s;
	logic ref_clk, reset_n, regWr, regRd, codeRd, supMonEn, supMonRstSel;
	logic porEvent, xramWr, xramRd, coreStall, dbgBusy, faultResetReq;
	logic seenS, seenF;
	logic [7:0] regAddr, regWdata, regRdata, codeRdata, xramWdata, dbgRdata;
	logic [7:0] rd;
	logic [13:0] codeAddr, corePc, xramAddr;
	fpeg_req_s coreReq, dbgReq;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	fpeg_row_s rows[4] = '{'{1'b1, 14'h0010, 8'h5A}, '{1'b0, 14'h0020, 8'h00},
		'{1'b1, 14'h3FFF, 8'hC3}, '{1'b0, 14'h3E00, 8'h00}};
	fpeg_flt_s flt[4] = '{'{1'b1, 1'b1, 1'b0, 14'h3E10},
		'{1'b0, 1'b1, 1'b0, 14'h0300}, '{1'b1, 1'b0, 1'b0, 14'h0300},
		'{1'b1, 1'b1, 1'b1, 14'h3E00}};
	logic [23:0] badKey[2] = '{24'hF1A5_06, 24'hA55A_02};
	fpeg_guard #(.ERASE_CYC(20), .WRITE_CYC(5)) fpeg_guard_i (.*);
	fpeg_core_model fpeg_core_model_i (.*);
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// cycle ceiling against hangs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic rst();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic rw(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rr(input logic [7:0] a);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask
	task automatic dbg(input logic wr, input logic [13:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		dbgReq <= {1'b1, wr, a, d};
		@(posedge ref_clk);
		dbgReq <= {1'b0, ~wr, ~a, ~d};
	endtask
	// note any stall or fault over n cycles
	task automatic watch(input int n);
		seenS = 1'b0;
		seenF = 1'b0;
		repeat (n) begin
			#1;
			seenS |= coreStall;
			seenF |= faultResetReq;
			@(posedge ref_clk);
		end
	endtask
	// keyed flash write; ctl bit1 asks for erase
	task automatic fw(input logic [7:0] ctl, input logic [13:0] a,
		input logic [7:0] d);
		rw(8'h00, `FPEG_KEY_FIRST);
		rw(8'h00, `FPEG_KEY_SECOND);
		if (ctl[1])
			rw(8'h01, 8'h02);
		rw(8'h01, ctl);
		fpeg_core_model_i.dm(1'b1, a, d);
		watch(30);
		chk(coreStall, 1'b0);
		rw(8'h01, ctl & 8'h02);
		rw(8'h01, 8'h00);
	endtask
	initial begin
		reset_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		corePc = 14'h0400;
		dbgReq = '0;
		supMonEn = 1'b1;
		supMonRstSel = 1'b1;
		porEvent = 1'b1; // power-on is the cause of the first reset
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		porEvent <= 1'b0;
		repeat (2) @(posedge ref_clk);
		// quiet outputs and clear fault flag after power-on
		#1 chk({coreStall, faultResetReq, xramWr, xramRd}, 4'h0);
		rr(8'h02);
		chk(rd[6], 1'b0);
		// plain data-move traffic, write enable clear
		foreach (rows[i]) begin
			fpeg_core_model_i.dm(rows[i].wr, rows[i].a, rows[i].d);
			#1 chk(xramWr, rows[i].wr);
			chk(xramRd, !rows[i].wr);
			chk(xramAddr, rows[i].a);
			if (rows[i].wr)
				chk(xramWdata, rows[i].d);
		end
		// erase page one, then program one byte twice
		fw(8'h03, 14'h0234, 8'h00);
		chk(seenS, 1'b1);
		fpeg_core_model_i.cm(14'h0200);
		#1 chk(codeRdata, 8'hFF);
		fpeg_core_model_i.cm(14'h03FF);
		#1 chk(codeRdata, 8'hFF);
		fw(8'h01, 14'h0234, 8'h3C);
		fw(8'h01, 14'h0234, 8'hF0);
		fpeg_core_model_i.cm(14'h0234);
		#1 chk(codeRdata, 8'h30);
		fpeg_core_model_i.cm(14'h0235);
		#1 chk(codeRdata, 8'hFF);
		// erase through another byte of the page brings back ones
		fw(8'h03, 14'h03FF, 8'h00);
		fpeg_core_model_i.cm(14'h0234);
		#1 chk(codeRdata, 8'hFF);
		// debug port writes with no key
		dbg(1'b1, 14'h0240, 8'h5A);
		#1 chk(dbgBusy, 1'b1);
		repeat (12) @(posedge ref_clk);
		dbg(1'b0, 14'h0240, 8'h00);
		#1 chk(dbgRdata, 8'h5A);
		// enable set without fresh keys kills the key
		corePc <= 14'h0600;
		rw(8'h01, 8'h01);
		fpeg_core_model_i.dm(1'b1, 14'h0236, 8'h00);
		watch(30);
		chk(seenS, 1'b0);
		rr(8'h03);
		chk(rd & 8'h06, 8'h06);
		fw(8'h01, 14'h0236, 8'h00);
		chk(seenS, 1'b0);
		// wrong key order or value
		foreach (badKey[i]) begin
			rst();
			rw(8'h00, badKey[i][23:16]);
			rr(8'h03);
			chk(rd & 8'h06, badKey[i][7:0]);
			rw(8'h00, badKey[i][15:8]);
			fw(8'h01, 14'h0238, 8'h00);
			chk(seenS, 1'b0);
		end
		// fault resets; the flag must survive the reset that follows
		foreach (flt[i]) begin
			rst();
			supMonEn <= flt[i].sm;
			supMonRstSel <= flt[i].sel;
			if (flt[i].code) begin
				fpeg_core_model_i.cm(flt[i].a);
				watch(1);
			end else begin
				fw(8'h01, flt[i].a, 8'h00);
			end
			chk(seenS, 1'b0);
			chk(seenF, 1'b1);
			rst();
			rr(8'h02);
			chk(rd[6], 1'b1);
		end
		// lock two pages through the lock byte, then probe each path
		dbg(1'b1, 14'h3DFF, 8'hFD);
		repeat (8) @(posedge ref_clk);
		rst();
		dbg(1'b0, 14'h0010, 8'h00);
		#1 chk(dbgRdata, 8'h00);
		corePc <= 14'h0100;
		fpeg_core_model_i.cm(14'h0240);
		watch(1);
		chk(codeRdata, 8'h5A);
		chk(seenF, 1'b0);
		corePc <= 14'h0600;
		fpeg_core_model_i.cm(14'h0100);
		watch(1);
		chk(seenF, 1'b1);
		fw(8'h01, 14'h0050, 8'h00);
		chk(seenF, 1'b1);
		chk(seenS, 1'b0);
		@(posedge ref_clk);
		porEvent <= 1'b1;
		@(posedge ref_clk);
		porEvent <= 1'b0;
		rr(8'h02);
		chk(rd[6], 1'b0);
		close_out();
	end
endmodule
bind fpeg_guard fpeg_guard_chk #(.ERASE_CYC(ERASE_CYC)) fpeg_guard_chk_i (.*);
